// ==== mcit_core.sv ====
`timescale 1ns/10ps
module mcit_core (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic prog_mode_i,
   input wire logic code_write_disable_i,
   input wire logic instr_valid_i,
   input wire mcit_pkg::mcit_instr_s instr_i,
   output logic instr_ready_o,
   output logic [9:0] oper_addr_o,
   output logic oper_code_o,
   input wire logic ee_done_i,
   output logic ee_ready_o,
   input wire mcit_pkg::mcit_cwr_s prog_wr_i,
   output mcit_pkg::mcit_cwr_s code_wr_o,
   output logic code_wr_refused_o,
   output logic fetch_en_o,
   output logic [9:0] pc_o,
   output logic [7:0] acc_o,
   output logic [10:0] index_pointer_o,
   output mcit_pkg::mcit_flags_s flags_o,
   output mcit_pkg::mcit_mem_s mem_o,
   output logic skip_o,
   output logic push_valid_o,
   output logic [9:0] push_addr_o
);
   import mcit_pkg::*;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic mcit_alu_s alu(input mcit_op_e op, input logic [7:0] a,
                                     input logic [7:0] b, input logic cin,
                                     input logic [2:0] bn);
      logic [8:0] sum;
      logic [4:0] low;
      mcit_alu_s r;
      sum = 9'h000;
      low = 5'h00;
      r = '0;
      case (op)
         OP_ADC, OP_ADD: begin
            sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == OP_ADC) & cin};
            low = {1'b0, a[3:0]} + {1'b0, b[3:0]} +
                  {4'h0, (op == OP_ADC) & cin};
            r = '{res: sum[7:0], c: sum[8], h: low[4]};
         end
         OP_SUBTRACT_WITH_CARRY: begin
            // Carry acts as not-borrow, so subtraction reuses the adder
            sum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
            low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
            r = '{res: sum[7:0], c: sum[8], h: low[4]};
         end
         OP_AND: r.res = a & b;
         OP_OR: r.res = a | b;
         OP_XOR: r.res = a ^ b;
         OP_INC: r.res = b + 8'h01;
         OP_DEC: r.res = b - 8'h01;
         OP_CLR: r = '{res: 8'h00, c: 1'b0, h: 1'b0};
         OP_SBIT: r.res = b | (8'h01 << bn);
         OP_RBIT: r.res = b & ~(8'h01 << bn);
         OP_STC: r.res = cin ? (b | (8'h01 << bn)) : (b & ~(8'h01 << bn));
         OP_LDC: r.c = b[bn];
         OP_RLC: r = '{res: {b[6:0], cin}, c: b[7], h: 1'b0};
         OP_RRC: r = '{res: {cin, b[7:1]}, c: b[0], h: 1'b0};
         OP_SC: r = '{res: 8'h00, c: 1'b1, h: 1'b1};
         OP_RC: r = '{res: 8'h00, c: 1'b0, h: 1'b0};
         OP_INVC: r.c = ~cin;
         default: r.res = b;
      endcase
      return r;
   endfunction : alu

   function automatic logic skip_cond(input mcit_op_e op, input logic [7:0] l,
                                      input logic [7:0] r, input logic c,
                                      input logic [2:0] bn);
      logic take;
      take = 1'b1;
      case (op)
         OP_IFEQ: take = (l == r);
         OP_IFNE: take = (l != r);
         OP_IFGT: take = (l > r);
         OP_IFLT: take = (l < r);
         OP_IFC: take = c;
         OP_IFNC: take = ~c;
         OP_BIT_SET_TEST_SKIP: take = r[bn];
         OP_BIT_CLEAR_TEST_SKIP: take = ~r[bn];
         default: take = 1'b1;
      endcase
      return ~take;
   endfunction : skip_cond

   // ----------------------------------------
   // State
   // ----------------------------------------
   mcit_state_e state_q, state_d;
   logic prog_meta_q, prog_sync_q;
   logic [2:0] cnt_q, cnt_d;
   logic [9:0] pc_q, pc_d;
   logic [7:0] acc_q, acc_d;
   logic [10:0] x_q, x_d;
   mcit_flags_s flags_q, flags_d, flags_new;
   logic ee_busy_q;
   mcit_mem_s mem_q, mem_d;
   mcit_cwr_s cwr_q, cwr_d;
   logic refused_q, skip_q, push_q;
   logic [9:0] push_addr_q;
   mcit_timing_s tim;

   mcit_timing u_timing (
      .op_i(instr_i.op),
      .mode_i(instr_i.mode),
      .tgt_i(instr_i.tgt),
      .tim_o(tim)
   );

   // ----------------------------------------
   // Decode and address wires
   // ----------------------------------------
   wire issue = instr_valid_i && instr_ready_o;
   wire mcit_op_e op = instr_i.op;
   wire [10:0] idx_sum = x_q + {3'h0, instr_i.imm[7:0]};
   wire is_idx = instr_i.mode == MD_IDX;
   wire is_ind = instr_i.mode == MD_IND;
   assign oper_code_o = is_idx & idx_sum[MCIT_X_SEL_BIT];
   assign oper_addr_o = is_idx ? idx_sum[9:0] :
                        is_ind ? {2'h0, x_q[7:0]} :
                        {2'h0, instr_i.imm[7:0]};
   wire [9:0] pc_seq = pc_q + {8'h00, tim.bytes};
   wire [9:0] pc_one = pc_q + 10'h001;
   wire [9:0] jp_mag = {5'h00, instr_i.opcode[4:0]};
   wire jp_fwd = instr_i.opcode[MCIT_JP_DIR_BIT];
   wire [9:0] jp_tgt = jp_fwd ? pc_one + jp_mag : pc_one - jp_mag;
   wire is_jp = op == OP_JP &&
                (instr_i.opcode & MCIT_JP_BASE) == MCIT_JP_BASE;
   wire [9:0] far_tgt = is_idx ? idx_sum[9:0] : instr_i.imm[9:0];
   wire is_far = op == OP_JMP || op == OP_JSR || op == OP_RET ||
                 op == OP_INTERRUPT_RETURN || op == OP_SOFTWARE_INTERRUPT;
   wire [7:0] alu_a = acc_q;
   wire [7:0] alu_b = (instr_i.tgt == TG_A && instr_i.mode == MD_INH) ?
                      acc_q : instr_i.opnd;
   wire mcit_alu_s alu_r = alu(op, alu_a, alu_b, flags_q.c, instr_i.bitn);
   wire [10:0] x_inc = x_q + 11'h001;
   wire [10:0] x_dec = x_q - 11'h001;
   wire [7:0] cmp_l = (instr_i.tgt == TG_X) ? x_q[7:0] : acc_q;
   wire [7:0] cmp_r = (instr_i.tgt == TG_X) ? instr_i.imm[7:0] :
                      instr_i.opnd;
   wire is_alu_m = instr_i.tgt == TG_M &&
                   (op == OP_INC || op == OP_DEC || op == OP_CLR ||
                    op == OP_SBIT || op == OP_RBIT || op == OP_RLC ||
                    op == OP_RRC || op == OP_STC);
   wire is_mem_wr = op == OP_ST || is_alu_m ||
                    (op == OP_LD && instr_i.tgt == TG_M);
   wire wr_ok = issue && is_mem_wr && !oper_code_o;
   wire ee_hit = oper_addr_o[7:0] >= MCIT_EE_FIRST &&
                 oper_addr_o[7:0] <= MCIT_EE_LAST;
   wire ee_start = wr_ok && ee_hit;
   wire prog_ok = prog_sync_q && !code_write_disable_i;

   // ----------------------------------------
   // Mode sequencing
   // ----------------------------------------
   always_comb begin
      case (state_q)
         ST_RESET: state_d = prog_sync_q ? ST_PROG : ST_RUN;
         ST_RUN: state_d = prog_sync_q ? ST_PROG : ST_RUN;
         ST_PROG: state_d = prog_sync_q ? ST_PROG : ST_RUN;
         default: state_d = ST_RESET;
      endcase
   end

   assign instr_ready_o = state_q == ST_RUN && cnt_q == 3'h0;
   assign fetch_en_o = state_q == ST_RUN;
   assign cnt_d = issue ? tim.cycles - 3'h1 :
                  (cnt_q != 3'h0) ? cnt_q - 3'h1 : cnt_q;

   // ----------------------------------------
   // Execute effects
   // ----------------------------------------
   always_comb begin
      pc_d = pc_q;
      acc_d = acc_q;
      x_d = x_q;
      flags_new = '{c: alu_r.c, h: alu_r.h, z: alu_r.res == 8'h00,
                    n: alu_r.res[7]};
      if (issue) begin
         pc_d = is_jp ? jp_tgt : is_far ? far_tgt : pc_seq;
         if (instr_i.tgt == TG_X) begin
            case (op)
               OP_LD: x_d = instr_i.imm[10:0];
               OP_INC: x_d = x_inc;
               OP_DEC: x_d = x_dec;
               OP_CLR: x_d = MCIT_X_RST;
               default: x_d = x_q;
            endcase
            flags_new.z = x_d == 11'h000;
         end else if (instr_i.tgt == TG_A) begin
            case (op)
               OP_LD: acc_d = instr_i.opnd;
               OP_ADC, OP_ADD, OP_AND, OP_OR, OP_SUBTRACT_WITH_CARRY, OP_XOR, OP_CLR,
               OP_INC, OP_DEC, OP_RLC, OP_RRC: acc_d = alu_r.res;
               default: acc_d = acc_q;
            endcase
         end
      end
   end

   assign flags_d = issue ? (flags_q & ~tim.fmask) |
                            (flags_new & tim.fmask) : flags_q;

   always_comb begin
      mem_d = '0;
      mem_d.valid = wr_ok;
      mem_d.we = wr_ok;
      mem_d.code = oper_code_o;
      mem_d.addr = oper_addr_o;
      mem_d.wdata = (op == OP_ST) ? acc_q :
                    is_alu_m ? alu_r.res : instr_i.opnd;
      cwr_d = '0;
      if (prog_wr_i.valid && prog_ok) begin
         cwr_d = prog_wr_i;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Programming-mode pin is asynchronous to the core clock
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prog_meta_q <= 1'b0;
         prog_sync_q <= 1'b0;
         state_q <= ST_RESET;
         cnt_q <= 3'h0;
      end else begin
         prog_meta_q <= prog_mode_i;
         prog_sync_q <= prog_meta_q;
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pc_q <= MCIT_PC_RST;
         acc_q <= MCIT_A_RST;
         x_q <= MCIT_X_RST;
         flags_q <= '0;
      end else begin
         pc_q <= pc_d;
         acc_q <= acc_d;
         x_q <= x_d;
         flags_q <= flags_d;
      end
   end

   // New write start beats a completion in the same cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ee_busy_q <= 1'b0;
      end else if (ee_start) begin
         ee_busy_q <= 1'b1;
      end else if (ee_done_i) begin
         ee_busy_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mem_q <= '0;
         cwr_q <= '0;
         refused_q <= 1'b0;
         skip_q <= 1'b0;
         push_q <= 1'b0;
         push_addr_q <= MCIT_PC_RST;
      end else begin
         mem_q <= mem_d;
         cwr_q <= cwr_d;
         refused_q <= prog_wr_i.valid && !prog_ok;
         skip_q <= issue && skip_cond(op, cmp_l, cmp_r, flags_q.c,
                                      instr_i.bitn);
         push_q <= issue && (op == OP_JSR || op == OP_SOFTWARE_INTERRUPT);
         push_addr_q <= pc_seq;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ee_ready_o = ~ee_busy_q;
   assign code_wr_o = cwr_q;
   assign code_wr_refused_o = refused_q;
   assign pc_o = pc_q;
   assign acc_o = acc_q;
   assign index_pointer_o = x_q;
   assign flags_o = flags_q;
   assign mem_o = mem_q;
   assign skip_o = skip_q;
   assign push_valid_o = push_q;
   assign push_addr_o = push_addr_q;

endmodule : mcit_core

// ==== mcit_core_asserts.sv ====
`timescale 1ns/10ps
module mcit_core_asserts
   import mcit_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic prog_mode_i,
   input wire logic code_write_disable_i,
   input wire logic instr_valid_i,
   input wire mcit_pkg::mcit_instr_s instr_i,
   input wire logic instr_ready_o,
   input wire logic [9:0] oper_addr_o,
   input wire logic oper_code_o,
   input wire logic ee_done_i,
   input wire logic ee_ready_o,
   input wire mcit_pkg::mcit_cwr_s prog_wr_i,
   input wire mcit_pkg::mcit_cwr_s code_wr_o,
   input wire logic code_wr_refused_o,
   input wire logic [9:0] pc_o,
   input wire logic [10:0] index_pointer_o,
   input wire mcit_pkg::mcit_mem_s mem_o
);
   wire logic take;
   wire logic ee_wr;
   wire logic [9:0] jp_off;
   wire logic [9:0] jp_tgt;
   assign take = instr_valid_i && instr_ready_o;
   assign jp_off = {5'h0, instr_i.opcode[4:0]};
   assign jp_tgt = instr_i.opcode[5] ? pc_o + 10'h1 + jp_off
                                     : pc_o + 10'h1 - jp_off;
   assign ee_wr = mem_o.valid && mem_o.we && !mem_o.code
      && mem_o.addr >= {2'h0, MCIT_EE_FIRST}
      && mem_o.addr <= {2'h0, MCIT_EE_LAST};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_ind_addr;
      instr_i.mode == MD_IND |-> !oper_code_o
         && oper_addr_o == {2'h0, index_pointer_o[7:0]};
   endproperty
   a_ind_addr: assert property (p_ind_addr) else $error("ind addr");
   property p_idx_addr;
      instr_i.mode == MD_IDX |-> {oper_code_o, oper_addr_o}
         == index_pointer_o + {3'h0, instr_i.imm[7:0]};
   endproperty
   a_idx_addr: assert property (p_idx_addr) else $error("idx addr");
   property p_rel_jump;
      take && instr_i.op == OP_JP && instr_i.opcode[7:6] == 2'h3
         |=> pc_o == $past(jp_tgt);
   endproperty
   a_rel_jump: assert property (p_rel_jump) else $error("rel jump");
   property p_idx_cyc;
      take && instr_i.mode == MD_IDX && instr_i.op != OP_JSR
         |=> !instr_ready_o [*2] ##1 instr_ready_o;
   endproperty
   a_idx_cyc: assert property (p_idx_cyc) else $error("idx cycles");
   property p_call_cyc;
      take && instr_i.op inside {OP_JSR, OP_RET, OP_INTERRUPT_RETURN, OP_SOFTWARE_INTERRUPT}
         |=> !instr_ready_o [*4] ##1 instr_ready_o;
   endproperty
   a_call_cyc: assert property (p_call_cyc) else $error("call cyc");
   property p_ee_busy;
      ee_wr |-> !ee_ready_o;
   endproperty
   a_ee_busy: assert property (p_ee_busy) else $error("ee busy");
   property p_ee_done;
      ee_done_i && !take |=> ee_ready_o;
   endproperty
   a_ee_done: assert property (p_ee_done) else $error("ee done");
   // Pin is synchronised, so only a steady level is judged
   property p_refuse;
      prog_wr_i.valid && (code_write_disable_i || !prog_mode_i
         && !$past(prog_mode_i) && !$past(prog_mode_i, 2)
         && !$past(prog_mode_i, 3)) |=> code_wr_refused_o && !code_wr_o.valid;
   endproperty
   a_refuse: assert property (p_refuse) else $error("code refuse");
   property p_no_code_st;
      mem_o.valid && mem_o.we |-> !mem_o.code;
   endproperty
   a_no_code_st: assert property (p_no_code_st) else $error("code st");
   c_jp: cover property (take && instr_i.op == OP_JP);
   c_ee: cover property (ee_wr);
   c_cwr: cover property (code_wr_o.valid);
endmodule : mcit_core_asserts

bind mcit_core mcit_core_asserts i_chk (
   .clk_i, .sys_rst_i, .prog_mode_i, .code_write_disable_i, .instr_valid_i,
   .instr_i, .instr_ready_o, .oper_addr_o, .oper_code_o, .ee_done_i,
   .ee_ready_o, .prog_wr_i, .code_wr_o, .code_wr_refused_o, .pc_o,
   .index_pointer_o, .mem_o
);

// ==== mcit_core_tb_top.sv ====
`timescale 1ns/10ps
module mcit_core_tb_top;
   import mcit_pkg::*;
   logic clk_i, sys_rst_i, prog_mode_i, code_write_disable_i;
   logic instr_valid_i, ee_done_i, instr_ready_o, oper_code_o, ee_ready_o;
   logic code_wr_refused_o, fetch_en_o, skip_o, push_valid_o;
   logic [9:0] oper_addr_o, pc_o, push_addr_o;
   logic [7:0] acc_o;
   logic [10:0] index_pointer_o;
   mcit_instr_s instr_i;
   mcit_cwr_s prog_wr_i, code_wr_o, cwr_seen;
   mcit_flags_s flags_o;
   mcit_mem_s mem_o, mem_seen;
   int fails, n_checks, n_mem, n_cwr, n_ref, cyc, k;

   mcit_core i_dut (
      .clk_i, .sys_rst_i, .prog_mode_i, .code_write_disable_i,
      .instr_valid_i, .instr_i, .instr_ready_o, .oper_addr_o, .oper_code_o,
      .ee_done_i, .ee_ready_o, .prog_wr_i, .code_wr_o, .code_wr_refused_o,
      .fetch_en_o, .pc_o, .acc_o, .index_pointer_o, .flags_o, .mem_o,
      .skip_o, .push_valid_o, .push_addr_o
   );

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // Pulse monitor, mid-cycle to stay clear of the edge
   // ----------------------------------------
   always @(negedge clk_i) begin
      cyc++;
      if (mem_o.valid === 1'b1) begin
         n_mem++;
         mem_seen = mem_o;
      end
      if (code_wr_o.valid === 1'b1) begin
         n_cwr++;
         cwr_seen = code_wr_o;
      end
      if (code_wr_refused_o === 1'b1) n_ref++;
      if (cyc > 2000) begin
         fails++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [23:0] seen,
                      input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic issue(input mcit_op_e op, input mcit_mode_e md,
         input mcit_tgt_e tg, input logic [7:0] oc, input logic [7:0] od,
         input logic [11:0] im);
      int n;
      n = 0;
      @(posedge clk_i);
      while (instr_ready_o !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_i);
      end
      instr_i <= '{op, md, tg, oc, od, im, 3'h0};
      instr_valid_i <= 1'b1;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
   endtask : issue

   task automatic run(input mcit_op_e op, input mcit_mode_e md,
         input mcit_tgt_e tg, input logic [7:0] oc, input logic [7:0] od,
         input logic [11:0] im);
      issue(op, md, tg, oc, od, im);
      @(posedge clk_i);
   endtask : run

   task automatic tcyc(input mcit_op_e op, input mcit_mode_e md,
         input mcit_tgt_e tg, input logic [2:0] c);
      int n;
      n = 0;
      issue(op, md, tg, 8'hc0, 8'h00, 12'h000);
      @(posedge clk_i);
      while (instr_ready_o !== 1'b1 && n < 8) begin
         n++;
         @(posedge clk_i);
      end
      chk("cycles", 24'(n), 24'(c) - 24'h1);
   endtask : tcyc

   task automatic wr_code(input logic [9:0] a, input logic [7:0] d);
      prog_wr_i <= '{1'b1, a, d};
      @(posedge clk_i);
      prog_wr_i <= '0;
      repeat (3) @(posedge clk_i);
   endtask : wr_code

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {fails, n_checks, n_mem, n_cwr, n_ref, cyc} = '0;
      {prog_mode_i, code_write_disable_i, instr_valid_i, ee_done_i} = '0;
      instr_i = '0;
      prog_wr_i = '0;
      sys_rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("fetch", fetch_en_o, 1'b1);
      chk("pc", pc_o, 10'h000);
      chk("ee rdy", ee_ready_o, 1'b1);
      $display("test reset done");
      tcyc(OP_ADC, MD_IND, TG_A, 3'h1);
      tcyc(OP_SUBTRACT_WITH_CARRY, MD_IDX, TG_A, 3'h3);
      tcyc(OP_ADD, MD_DIR, TG_A, 3'h2);
      tcyc(OP_LD, MD_IMM, TG_A, 3'h2);
      tcyc(OP_CLR, MD_DIR, TG_M, 3'h1);
      tcyc(OP_SBIT, MD_IND, TG_M, 3'h2);
      tcyc(OP_LD, MD_LONG, TG_X, 3'h3);
      tcyc(OP_JMP, MD_ABS, TG_NONE, 3'h4);
      tcyc(OP_JMP, MD_IDX, TG_NONE, 3'h3);
      tcyc(OP_JSR, MD_ABS, TG_NONE, 3'h5);
      tcyc(OP_JSR, MD_IDX, TG_NONE, 3'h5);
      tcyc(OP_RET, MD_INH, TG_NONE, 3'h5);
      tcyc(OP_INTERRUPT_RETURN, MD_INH, TG_NONE, 3'h5);
      tcyc(OP_SOFTWARE_INTERRUPT, MD_INH, TG_NONE, 3'h5);
      tcyc(OP_JP, MD_REL, TG_NONE, 3'h1);
      $display("test cycles done");
      run(OP_CLR, MD_INH, TG_A, 8'h00, 8'h00, 12'h000);
      chk("flags", flags_o, 4'h2);
      run(OP_LD, MD_IMM, TG_A, 8'h00, 8'h8f, 12'h000);
      run(OP_ADC, MD_IMM, TG_A, 8'h00, 8'h81, 12'h000);
      chk("acc", acc_o, 8'h10);
      chk("flags", flags_o, 4'hc);
      run(OP_ADD, MD_IMM, TG_A, 8'h00, 8'hf0, 12'h000);
      chk("flags", flags_o, 4'he);
      run(OP_INC, MD_INH, TG_A, 8'h00, 8'h00, 12'h000);
      chk("flags", flags_o, 4'hc);
      run(OP_IFEQ, MD_IMM, TG_A, 8'h00, 8'h02, 12'h000);
      chk("skip", skip_o, 1'b1);
      chk("flags", flags_o, 4'hc);
      run(OP_IFEQ, MD_IMM, TG_A, 8'h00, 8'h01, 12'h000);
      chk("skip", skip_o, 1'b0);
      $display("test flags done");
      run(OP_JMP, MD_ABS, TG_NONE, 8'h00, 8'h00, 12'hc20);
      chk("pc", pc_o, 10'h020);
      run(OP_JP, MD_REL, TG_NONE, 8'hff, 8'h00, 12'h000);
      chk("pc", pc_o, 10'h040);
      run(OP_JP, MD_REL, TG_NONE, 8'hde, 8'h00, 12'h000);
      chk("pc", pc_o, 10'h023);
      run(OP_JSR, MD_ABS, TG_NONE, 8'h00, 8'h00, 12'hd23);
      chk("push", push_valid_o, 1'b1);
      chk("ret addr", push_addr_o, 10'h026);
      chk("pc", pc_o, 10'h123);
      $display("test jumps done");
      run(OP_LD, MD_LONG, TG_X, 8'h00, 8'h00, 12'hc05);
      chk("x", index_pointer_o, 11'h405);
      instr_i <= '{OP_LD, MD_IDX, TG_A, 8'h00, 8'h00, 12'h010, 3'h0};
      @(posedge clk_i);
      chk("ea", {oper_code_o, oper_addr_o}, 11'h415);
      instr_i <= '{OP_LD, MD_IND, TG_A, 8'h00, 8'h00, 12'h000, 3'h0};
      @(posedge clk_i);
      chk("ea", {oper_code_o, oper_addr_o}, 11'h005);
      k = n_mem;
      run(OP_ST, MD_IDX, TG_M, 8'h00, 8'h00, 12'h001);
      repeat (3) @(posedge clk_i);
      chk("code st", 24'(n_mem - k), 24'h0);
      $display("test pointer done");
      run(OP_LD, MD_LONG, TG_X, 8'h00, 8'h00, 12'h050);
      run(OP_ST, MD_IND, TG_M, 8'h00, 8'h00, 12'h000);
      repeat (4) @(posedge clk_i);
      chk("ee rdy", ee_ready_o, 1'b0);
      chk("mem", {mem_seen.we, mem_seen.code, mem_seen.addr}, 12'h850);
      chk("wdata", mem_seen.wdata, 8'h01);
      ee_done_i <= 1'b1;
      @(posedge clk_i);
      ee_done_i <= 1'b0;
      @(posedge clk_i);
      chk("ee rdy", ee_ready_o, 1'b1);
      run(OP_LD, MD_LONG, TG_X, 8'h00, 8'h00, 12'h010);
      run(OP_ST, MD_IND, TG_M, 8'h00, 8'h00, 12'h000);
      repeat (3) @(posedge clk_i);
      chk("sram rdy", ee_ready_o, 1'b1);
      $display("test eeprom done");
      k = n_ref;
      wr_code(10'h155, 8'h5a);
      chk("refused", 24'(n_ref - k), 24'h1);
      prog_mode_i <= 1'b1;
      code_write_disable_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      wr_code(10'h155, 8'h5a);
      chk("refused", 24'(n_ref - k), 24'h2);
      code_write_disable_i <= 1'b0;
      wr_code(10'h2a3, 8'hc3);
      chk("written", 24'(n_cwr), 24'h1);
      chk("cwr", {cwr_seen.addr, cwr_seen.data}, 24'h2a3c3);
      prog_mode_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      $display("test code write done");
      end_sim();
   end
endmodule : mcit_core_tb_top

// ==== mcit_pkg.sv ====
package mcit_pkg;

   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int unsigned MCIT_PC_W = 10;
   localparam int unsigned MCIT_X_W = 11;
   localparam int unsigned MCIT_IMM_W = 12;
   localparam int unsigned MCIT_X_SEL_BIT = 10;
   localparam int unsigned MCIT_JP_DIR_BIT = 5;
   localparam logic [9:0] MCIT_PC_RST = 10'h000;
   localparam logic [10:0] MCIT_X_RST = 11'h000;
   localparam logic [7:0] MCIT_A_RST = 8'h00;
   localparam logic [7:0] MCIT_JP_BASE = 8'hc0;
   localparam logic [7:0] MCIT_EE_FIRST = 8'h40;
   localparam logic [7:0] MCIT_EE_LAST = 8'h7f;

   // ----------------------------------------
   // Instruction lengths and cycle counts
   // ----------------------------------------
   localparam logic [1:0] MCIT_BYTES_1 = 2'h1;
   localparam logic [1:0] MCIT_BYTES_2 = 2'h2;
   localparam logic [1:0] MCIT_BYTES_3 = 2'h3;
   localparam logic [2:0] MCIT_CYC_1 = 3'h1;
   localparam logic [2:0] MCIT_CYC_2 = 3'h2;
   localparam logic [2:0] MCIT_CYC_3 = 3'h3;
   localparam logic [2:0] MCIT_CYC_4 = 3'h4;
   localparam logic [2:0] MCIT_CYC_5 = 3'h5;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [5:0] {
      OP_ADC = 6'h00, OP_ADD = 6'h01, OP_AND = 6'h02, OP_OR = 6'h03,
      OP_SUBTRACT_WITH_CARRY = 6'h04, OP_XOR = 6'h05, OP_CLR = 6'h06, OP_INC = 6'h07,
      OP_DEC = 6'h08, OP_IFEQ = 6'h09, OP_IFGT = 6'h0a, OP_IFNE = 6'h0b,
      OP_IFLT = 6'h0c, OP_SC = 6'h0d, OP_RC = 6'h0e, OP_IFC = 6'h0f,
      OP_IFNC = 6'h10, OP_INVC = 6'h11, OP_LDC = 6'h12, OP_STC = 6'h13,
      OP_RLC = 6'h14, OP_RRC = 6'h15, OP_LD = 6'h16, OP_ST = 6'h17,
      OP_NOP = 6'h18, OP_BIT_SET_TEST_SKIP = 6'h19, OP_BIT_CLEAR_TEST_SKIP = 6'h1a,
      OP_SBIT = 6'h1b, OP_RBIT = 6'h1c, OP_JP = 6'h1d, OP_JSR = 6'h1e,
      OP_JMP = 6'h1f, OP_RET = 6'h20, OP_INTERRUPT_RETURN = 6'h21, OP_SOFTWARE_INTERRUPT = 6'h22
   } mcit_op_e;

   typedef enum logic [2:0] {
      MD_INH = 3'h0, MD_IMM = 3'h1, MD_DIR = 3'h2, MD_IND = 3'h3,
      MD_IDX = 3'h4, MD_ABS = 3'h5, MD_REL = 3'h6, MD_LONG = 3'h7
   } mcit_mode_e;

   typedef enum logic [1:0] {
      TG_A = 2'h0, TG_X = 2'h1, TG_M = 2'h2, TG_NONE = 2'h3
   } mcit_tgt_e;

   typedef enum logic [2:0] {
      ST_RESET = 3'b001, ST_RUN = 3'b010, ST_PROG = 3'b100
   } mcit_state_e;

   typedef struct packed {
      logic c;
      logic h;
      logic z;
      logic n;
   } mcit_flags_s;

   typedef struct packed {
      mcit_op_e op;
      mcit_mode_e mode;
      mcit_tgt_e tgt;
      logic [7:0] opcode;
      logic [7:0] opnd;
      logic [11:0] imm;
      logic [2:0] bitn;
   } mcit_instr_s;

   typedef struct packed {
      logic [1:0] bytes;
      logic [2:0] cycles;
      mcit_flags_s fmask;
   } mcit_timing_s;

   typedef struct packed {
      logic valid;
      logic we;
      logic code;
      logic [9:0] addr;
      logic [7:0] wdata;
   } mcit_mem_s;

   typedef struct packed {
      logic valid;
      logic [9:0] addr;
      logic [7:0] data;
   } mcit_cwr_s;

   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic h;
   } mcit_alu_s;

endpackage : mcit_pkg

// ==== mcit_timing.sv ====
`timescale 1ns/10ps
module mcit_timing (
   input wire mcit_pkg::mcit_op_e op_i,
   input wire mcit_pkg::mcit_mode_e mode_i,
   input wire mcit_pkg::mcit_tgt_e tgt_i,
   output mcit_pkg::mcit_timing_s tim_o
);
   import mcit_pkg::*;

   // ----------------------------------------
   // Length and cycle decode
   // ----------------------------------------
   always_comb begin
      tim_o.bytes = MCIT_BYTES_1;
      tim_o.cycles = MCIT_CYC_1;
      case (mode_i)
         MD_IND: begin
            tim_o.bytes = MCIT_BYTES_1;
            tim_o.cycles = (op_i == OP_SBIT || op_i == OP_RBIT) ?
                           MCIT_CYC_2 : MCIT_CYC_1;
         end
         MD_IDX: begin
            tim_o.bytes = MCIT_BYTES_2;
            tim_o.cycles = (op_i == OP_JSR) ? MCIT_CYC_5 : MCIT_CYC_3;
         end
         MD_IMM, MD_DIR: begin
            tim_o.bytes = MCIT_BYTES_2;
            tim_o.cycles = (op_i == OP_CLR) ? MCIT_CYC_1 : MCIT_CYC_2;
         end
         MD_ABS: begin
            tim_o.bytes = MCIT_BYTES_3;
            tim_o.cycles = (op_i == OP_JSR) ? MCIT_CYC_5 : MCIT_CYC_4;
         end
         MD_LONG: begin
            tim_o.bytes = MCIT_BYTES_3;
            tim_o.cycles = MCIT_CYC_3;
         end
         MD_INH: begin
            tim_o.bytes = MCIT_BYTES_1;
            tim_o.cycles = (op_i == OP_RET || op_i == OP_INTERRUPT_RETURN ||
                            op_i == OP_SOFTWARE_INTERRUPT) ? MCIT_CYC_5 : MCIT_CYC_1;
         end
         default: begin
            tim_o.bytes = MCIT_BYTES_1;
            tim_o.cycles = MCIT_CYC_1;
         end
      endcase
      // Masks share this process so tim_o keeps one driver
      tim_o.fmask = 4'b0000;
      case (op_i)
         OP_ADC, OP_SUBTRACT_WITH_CARRY: tim_o.fmask = 4'b1111;
         OP_CLR: tim_o.fmask = (tgt_i == TG_X) ? 4'b0010 : 4'b1111;
         OP_INC, OP_DEC: tim_o.fmask = (tgt_i == TG_X) ? 4'b0010 : 4'b0011;
         OP_ADD, OP_AND, OP_OR, OP_XOR: tim_o.fmask = 4'b0011;
         OP_SBIT, OP_RBIT, OP_STC: tim_o.fmask = 4'b0011;
         OP_RLC, OP_RRC: tim_o.fmask = 4'b1011;
         OP_SC, OP_RC: tim_o.fmask = 4'b1100;
         OP_INVC, OP_LDC: tim_o.fmask = 4'b1000;
         default: tim_o.fmask = 4'b0000;
      endcase
   end

endmodule : mcit_timing
